// *** src/aicb_pkg.sv ***
// shared constants and types for the adc irq latch, bias and channel-1 config slice
package aicb_pkg;
  localparam logic [7:0] ADDR_IRQ_CFG = 8'h32;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h33;
  localparam logic [7:0] ADDR_IRQ_LATCH = 8'h36;
  localparam logic [7:0] ADDR_BIAS_CFG = 8'h3b;
  localparam logic [7:0] ADDR_CH1_CFG = 8'h3c;
  localparam logic [7:0] ADDR_AGC_CTRL = 8'h6c;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam int BIT_CLK_ERR = 7;
  localparam int BIT_PLL_LOCK = 6;
  localparam int BIT_READBACK_SEL = 2;
  localparam int BIT_AGC_MODE = 3;
  localparam logic [7:0] BIAS_WMASK = 8'h73;
  localparam logic [7:0] CH1_WMASK = 8'hfd;
  localparam logic [7:0] CFG_WMASK = 8'he4;
  localparam logic [7:0] LATCH_BITS = 8'hc0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aicb_req_type;

  typedef struct packed {
    logic [2:0] mic_bias_select;
    logic [1:0] fullscale_select;
    logic chan1_input_kind;
    logic [1:0] chan1_source_select;
    logic chan1_coupling;
    logic [1:0] chan1_impedance;
    logic chan1_auto_gain_on;
  } aicb_cfg_type;
endpackage

// *** src/aicb_regs.sv ***
// control register slice: latched interrupts, bias and channel-1 configuration
`timescale 1ns/1ns
module aicb_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire aicb_pkg::aicb_req_type req_i,
  input wire logic clk_err_i,
  input wire logic pll_lock_i,
  output logic [7:0] rdata_o,
  output aicb_pkg::aicb_cfg_type cfg_o
);
  import aicb_pkg::*;

  logic [7:0] bias_fullscale_config;
  logic [7:0] chan1_input_config;
  logic [7:0] irq_cfg;
  logic [7:0] irq_mask_reg;
  logic [7:0] agc_control_reg;
  logic [7:0] latched_irq_status;
  logic [7:0] next_rdata;
  logic [7:0] latch_view;
  logic [1:0] evt_sync1;
  logic [1:0] evt_sync2;
  logic [1:0] evt_prev;
  logic [7:0] evt_set;
  logic latch_read;

  function automatic logic hit(input aicb_req_type r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // events come from other clock domains, so two flops before any use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_sync1 <= 2'h0;
      evt_sync2 <= 2'h0;
      evt_prev <= 2'h0;
    end else begin
      evt_sync1 <= {clk_err_i, pll_lock_i};
      evt_sync2 <= evt_sync1;
      evt_prev <= evt_sync2;
    end
  end

  always_comb begin
    evt_set = 8'h00;
    evt_set[BIT_CLK_ERR] = evt_sync2[1] & ~evt_prev[1];
    evt_set[BIT_PLL_LOCK] = evt_sync2[0] & ~evt_prev[0];
  end

  assign latch_read = req_i.rd && (req_i.addr == ADDR_IRQ_LATCH);

  // set wins over the read clear so an edge in the read cycle is kept
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latched_irq_status <= RST_ZERO;
    end else if (latch_read) begin
      latched_irq_status <= evt_set;
    end else begin
      latched_irq_status <= latched_irq_status | evt_set;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bias_fullscale_config <= RST_ZERO;
      chan1_input_config <= RST_ZERO;
      irq_cfg <= RST_ZERO;
      irq_mask_reg <= RST_MASK;
      agc_control_reg <= RST_ZERO;
    end else begin
      if (hit(req_i, ADDR_BIAS_CFG)) begin
        bias_fullscale_config <= req_i.wdata & BIAS_WMASK;
      end
      if (hit(req_i, ADDR_CH1_CFG)) begin
        chan1_input_config <= req_i.wdata & CH1_WMASK;
      end
      if (hit(req_i, ADDR_IRQ_CFG)) begin
        irq_cfg <= req_i.wdata & CFG_WMASK;
      end
      if (hit(req_i, ADDR_IRQ_MASK)) begin
        irq_mask_reg <= req_i.wdata;
      end
      if (hit(req_i, ADDR_AGC_CTRL)) begin
        agc_control_reg <= req_i.wdata;
      end
    end
  end

  // masked events stay latched; masking only hides them on readback, and only with irq_cfg readback select (bit 2) set
  assign latch_view = irq_cfg[BIT_READBACK_SEL] ?
    (latched_irq_status & ~irq_mask_reg & LATCH_BITS) : latched_irq_status;

  always_comb begin
    case (req_i.addr)
      ADDR_IRQ_CFG: next_rdata = irq_cfg;
      ADDR_IRQ_MASK: next_rdata = irq_mask_reg;
      ADDR_IRQ_LATCH: next_rdata = latch_view;
      ADDR_BIAS_CFG: next_rdata = bias_fullscale_config;
      ADDR_CH1_CFG: next_rdata = chan1_input_config;
      ADDR_AGC_CTRL: next_rdata = agc_control_reg;
      default: next_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= RST_ZERO;
    end else if (req_i.rd) begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.mic_bias_select <= bias_fullscale_config[6:4];
      cfg_o.fullscale_select <= bias_fullscale_config[1:0];
      cfg_o.chan1_input_kind <= chan1_input_config[7];
      cfg_o.chan1_source_select <= chan1_input_config[6:5];
      cfg_o.chan1_coupling <= chan1_input_config[4];
      cfg_o.chan1_impedance <= chan1_input_config[3:2];
      // agc runs only with both enable and mode bit set
      cfg_o.chan1_auto_gain_on <= chan1_input_config[0] & agc_control_reg[BIT_AGC_MODE];
    end
  end

  property p_clk_err_latch;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(evt_sync2[1]) |=> latched_irq_status[BIT_CLK_ERR];
  endproperty
  a_clk_err_latch: assert property (p_clk_err_latch) else $error("clk error not latched");

  property p_pll_latch;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(evt_sync2[0]) |=> latched_irq_status[BIT_PLL_LOCK];
  endproperty
  a_pll_latch: assert property (p_pll_latch) else $error("pll lock not latched");

  property p_read_clears;
    @(posedge clk_i) disable iff (!nrst_i)
    latch_read && !evt_set[BIT_CLK_ERR] |=> !latched_irq_status[BIT_CLK_ERR];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear latch");

  property p_bias_cfg;
    @(posedge clk_i) disable iff (!nrst_i)
    hit(req_i, ADDR_BIAS_CFG) |=> ##1 cfg_o.mic_bias_select == $past(req_i.wdata[6:4], 2);
  endproperty
  a_bias_cfg: assert property (p_bias_cfg) else $error("bias field wrong");

  property p_fullscale;
    @(posedge clk_i) disable iff (!nrst_i)
    hit(req_i, ADDR_BIAS_CFG) |=> ##1 cfg_o.fullscale_select == $past(req_i.wdata[1:0], 2);
  endproperty
  a_fullscale: assert property (p_fullscale) else $error("fullscale field wrong");

  property p_ch1_kind;
    @(posedge clk_i) disable iff (!nrst_i)
    hit(req_i, ADDR_CH1_CFG) |=> ##1 cfg_o.chan1_input_kind == $past(req_i.wdata[7], 2);
  endproperty
  a_ch1_kind: assert property (p_ch1_kind) else $error("input kind wrong");

  property p_ch1_src;
    @(posedge clk_i) disable iff (!nrst_i)
    hit(req_i, ADDR_CH1_CFG) |=> ##1 {cfg_o.chan1_source_select, cfg_o.chan1_coupling,
      cfg_o.chan1_impedance} == $past(req_i.wdata[6:2], 2);
  endproperty
  a_ch1_src: assert property (p_ch1_src) else $error("source fields wrong");

  property p_agc;
    @(posedge clk_i) disable iff (!nrst_i)
    cfg_o.chan1_auto_gain_on |-> $past(chan1_input_config[0]);
  endproperty
  a_agc: assert property (p_agc) else $error("agc on without enable");

  property p_masked_hidden;
    @(posedge clk_i) disable iff (!nrst_i)
    irq_cfg[BIT_READBACK_SEL] && irq_mask_reg[BIT_CLK_ERR] |-> !latch_view[BIT_CLK_ERR];
  endproperty
  a_masked_hidden: assert property (p_masked_hidden) else $error("masked irq visible");

  property p_read_clears_pll;
    @(posedge clk_i) disable iff (!nrst_i)
    latch_read && !evt_set[BIT_PLL_LOCK] |=> !latched_irq_status[BIT_PLL_LOCK];
  endproperty
  a_read_clears_pll: assert property (p_read_clears_pll) else $error("pll latch not cleared");

  // only a read may drop a latched bit
  property p_latch_keeps;
    @(posedge clk_i) disable iff (!nrst_i)
    !latch_read |=> ($past(latched_irq_status) & ~latched_irq_status) == RST_ZERO;
  endproperty
  a_latch_keeps: assert property (p_latch_keeps) else $error("latched irq lost");

  property p_no_spurious_err;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(latched_irq_status[BIT_CLK_ERR]) |-> $past(evt_set[BIT_CLK_ERR]);
  endproperty
  a_no_spurious_err: assert property (p_no_spurious_err) else $error("clk error without event");

  property p_unmasked_visible;
    @(posedge clk_i) disable iff (!nrst_i)
    irq_cfg[BIT_READBACK_SEL] && !irq_mask_reg[BIT_CLK_ERR] |->
      latch_view[BIT_CLK_ERR] == latched_irq_status[BIT_CLK_ERR];
  endproperty
  a_unmasked_visible: assert property (p_unmasked_visible) else $error("unmasked irq hidden");

  property p_agc_follows;
    @(posedge clk_i) disable iff (!nrst_i)
    hit(req_i, ADDR_CH1_CFG) |=> ##1 cfg_o.chan1_auto_gain_on ==
      ($past(req_i.wdata[0], 2) & $past(agc_control_reg[BIT_AGC_MODE]));
  endproperty
  a_agc_follows: assert property (p_agc_follows) else $error("agc output wrong");

  c_clk_err: cover property (@(posedge clk_i) disable iff (!nrst_i)
    latch_read && latched_irq_status[BIT_CLK_ERR]);
  c_set_on_read: cover property (@(posedge clk_i) disable iff (!nrst_i)
    latch_read && evt_set[BIT_PLL_LOCK]);
  c_agc_on: cover property (@(posedge clk_i) disable iff (!nrst_i) cfg_o.chan1_auto_gain_on);
  c_masked_read: cover property (@(posedge clk_i) disable iff (!nrst_i)
    latch_read && irq_cfg[BIT_READBACK_SEL] && latched_irq_status[BIT_PLL_LOCK]);
endmodule // aicb_regs

// *** tb/aicb_regs_test.sv ***
// self-checking bench for the irq latch, bias and channel-1 config slice
`timescale 1ns/1ns
module aicb_regs_test;
  import aicb_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  aicb_req_type req_i = '0;
  logic clk_err_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic [7:0] rdata_o;
  aicb_cfg_type cfg_o;
  int errors = 0;
  int total_checks = 0;
  // rows: address, data written, value read back; legal codes, reserved bits zero, except the 8'h50 row, an unmapped address that reads back zero
  // pdm source rows assume gp pins already set as pdm data and clock
  logic [7:0] rows [7][3] = '{'{8'h3b, 8'h10, 8'h10}, '{8'h3c, 8'h81, 8'h81},
    '{8'h3b, 8'h61, 8'h61}, '{8'h3c, 8'h34, 8'h34}, '{8'h32, 8'he4, 8'he4},
    '{8'h50, 8'haa, 8'h00}, '{8'h3c, 8'hd9, 8'hd9}};

  always #50 clk_i = ~clk_i;

  aicb_regs u_dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_i(req_i),
    .clk_err_i(clk_err_i),
    .pll_lock_i(pll_lock_i),
    .rdata_o(rdata_o),
    .cfg_o(cfg_o)
  );

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [11:0] d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 d = {4'h0, rdata_o};
  endtask

  // both sources rise together, then fall; sync takes a few edges
  task automatic events();
    @(posedge clk_i);
    clk_err_i <= 1'b1;
    pll_lock_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    clk_err_i <= 1'b0;
    pll_lock_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic give_verdict();
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(3000 * 100);
    errors++;
    give_verdict();
  end

  initial begin
    logic [11:0] d;
    repeat (20) @(posedge clk_i);
    check({4'h0, rdata_o}, 12'h000);
    check(cfg_o, 12'h000);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_BIAS_CFG, d);
    check(d, 12'h000);
    rd(ADDR_IRQ_MASK, d);
    check(d, 12'h0ff);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], d);
      check(d, {4'h0, rows[i][2]});
    end
    wr(ADDR_AGC_CTRL, 8'h08);
    rd(ADDR_AGC_CTRL, d);
    check(d, 12'h008);
    check(cfg_o, {3'h6, 2'h1, 1'b1, 2'h2, 1'b1, 2'h2, 1'b1});
    wr(ADDR_AGC_CTRL, 8'h00);
    rd(ADDR_CH1_CFG, d);
    check(cfg_o, {3'h6, 2'h1, 1'b1, 2'h2, 1'b1, 2'h2, 1'b0});
    wr(ADDR_IRQ_CFG, 8'h00);
    events();
    rd(ADDR_IRQ_LATCH, d);
    check(d, 12'h0c0);
    rd(ADDR_IRQ_LATCH, d);
    check(d, 12'h000);
    wr(ADDR_IRQ_CFG, 8'h04);
    events();
    rd(ADDR_IRQ_LATCH, d);
    check(d, 12'h000);
    wr(ADDR_IRQ_MASK, 8'h40);
    events();
    rd(ADDR_IRQ_LATCH, d);
    check(d, 12'h080);
    // second reset in mid-run must restore defaults
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({4'h0, rdata_o}, 12'h000);
    check(cfg_o, 12'h000);
    nrst_i <= 1'b1;
    rd(ADDR_CH1_CFG, d);
    check(d, 12'h000);
    rd(ADDR_IRQ_MASK, d);
    check(d, 12'h0ff);
    rd(ADDR_IRQ_CFG, d);
    check(d, 12'h000);
    give_verdict();
  end
endmodule // aicb_regs_test
